// [pkg/dcocs_pkg.sv]
// package: shared constants and types for the oscillator clock select block
package dcocs_pkg;
   // ------------------------------------------------------------
   // field widths and encodings
   // ------------------------------------------------------------
   localparam int RANGE_W = 4;                 // range select width
   localparam int TAP_W = 3;                   // tap field width
   localparam int MOD_W = 5;                   // modulation field width
   localparam int SEL_W = 2;                   // main source select width
   localparam logic [3:0] RANGE_DEFAULT = 4'h7; // range after power-up clear
   localparam logic [3:0] RANGE_MAX = 4'hF;     // highest range setting
   localparam logic [3:0] RANGE_HIGH_EDGE = 4'hD; // above this is high band
   localparam logic [3:0] RANGE_LOW_EDGE = 4'hC;  // below this is low band
   localparam logic [1:0] SEL_OSC_A = 2'h0;    // main select: oscillator
   localparam logic [1:0] SEL_OSC_B = 2'h1;    // main select: oscillator
   localparam logic [1:0] SEL_XT = 2'h2;       // main select: crystal
   localparam logic [1:0] SEL_LF = 2'h3;       // main select: low freq
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 25;                // ref_clk rate
   localparam int DEAD_TIME_US = 20;           // dead time after band jump
   localparam int DEAD_CYCLES = DEAD_TIME_US * CLK_MHZ; // 500 cycles
   localparam int DEAD_W = 10;                 // dead counter width
   localparam int OSC_DIV = 2;                 // half period of osc model
   // ------------------------------------------------------------
   // software register map on the plain port
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTL_ONE = 4'h0;  // range select
   localparam logic [3:0] ADDR_CTL_TWO = 4'h1;  // sources
   localparam logic [3:0] ADDR_TAP = 4'h2;      // tap and modulation
   localparam logic [3:0] ADDR_IFG = 4'h3;      // fault flag
   localparam logic [3:0] ADDR_STATUS = 4'h4;   // device status
   localparam logic [3:0] ADDR_INT_STAT = 4'h5; // sticky events
   localparam logic [3:0] ADDR_INT_MASK = 4'h6; // event mask
   localparam int EV_W = 3;                     // event bits
   localparam int EV_START = 0;                 // oscillator started
   localparam int EV_DEAD = 1;                  // dead time seen
   localparam int EV_HANG = 2;                  // dead time or hang entered at range 15
   // ------------------------------------------------------------
   // oscillator state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      DCOCS_OFF = 2'b00,   // oscillator stopped
      DCOCS_RUN = 2'b01,   // oscillator running
      DCOCS_DEAD = 2'b10,  // output frozen for dead time
      DCOCS_HANG = 2'b11   // stopped until power cycle
   } dcocs_osc_t;
endpackage : dcocs_pkg

// [pkg/dcocs_if.sv]
// interface: joins the controller and the clock system device
`timescale 1ns/1ps
interface dcocs_if;
   import dcocs_pkg::*;
   logic wr;                          // write strobe of a control field
   logic [3:0] addr;                  // field address
   logic [7:0] wdata;                 // field write data
   logic [3:0] range_q;               // current range select
   logic [1:0] main_sel_q;            // current main select
   logic sub_sel_osc_q;               // sub-main uses oscillator
   logic fault_q;                     // fault flag
   logic osc_on;                      // oscillator running
   logic osc_dead;                    // dead time or hang
   logic main_clock;                  // generated main clock
   logic sub_main_clock;              // generated sub-main clock
   modport device (input wr, addr, wdata,
      output range_q, main_sel_q, sub_sel_osc_q, fault_q, osc_on, osc_dead,
      main_clock, sub_main_clock);
   modport host (output wr, addr, wdata,
      input range_q, main_sel_q, sub_sel_osc_q, fault_q, osc_on, osc_dead,
      main_clock, sub_main_clock);
endinterface : dcocs_if

// [design/dcocs_device.sv]
// design: clock system device with oscillator, source muxes and defects
`timescale 1ns/1ps
// Operation
// - oscillator off when no clock selects it and the fault flag is clear
// - main select of oscillator starts it
// - sub-main select alone leaves it stopped, high
// - main codes 00 and 01 pick oscillator
// - fault flag set starts the oscillator
// - range resets to 7
// - range spans 0 to 15
// - band jump freezes output 20 us, maybe hangs
// - tap change at range 15 may hang
// - software steps through 13 going down
// - software goes via 12 going up
// - software leaves 15 before tap change
// - three-step start only right after reset
// - software restores crystal main afterwards
module dcocs_device
   import dcocs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // other sources, already on ref_clk
   input wire logic crystal_clock,
   input wire logic low_freq_clock,
   // hang selector for the occasional full stop
   input wire logic hang_on_jump,
   // link to the controller
   dcocs_if.device link
);
   import dcocs_pkg::*;
   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   logic [RANGE_W-1:0] range_reg, range_next;   // osc_range_select
   logic [SEL_W-1:0] msel_reg, msel_next;       // main_clock_source_select
   logic ssel_reg, ssel_next;                   // sub-main uses oscillator
   logic [TAP_W-1:0] tap_reg, tap_next;         // osc_tap_field
   logic [MOD_W-1:0] mod_reg, mod_next;         // osc_modulation_field
   logic fault_reg, fault_next;                 // osc_fault_flag
   logic jump_ev;                               // band jump on range write
   logic tap_ev;                                // tap write at top range
   logic main_osc;                              // main selects oscillator
   // ------------------------------------------------------------
   // oscillator model
   // ------------------------------------------------------------
   dcocs_osc_t osc_reg, osc_next;               // oscillator state
   logic [DEAD_W-1:0] dead_reg, dead_next;      // dead time counter
   logic [3:0] div_reg, div_next;               // output toggle divider
   logic tick_reg, tick_next;                   // oscillator output
   logic mclk_reg, mclk_next;                   // main clock output
   logic sclk_reg, sclk_next;                   // sub-main clock output
   logic [1:0] msrc_reg, msrc_next;             // applied main source
   logic ssrc_reg, ssrc_next;                   // applied sub source
   logic mux_main, mux_sub;                     // raw mux values

   // main codes 00 and 01 both mean oscillator
   assign main_osc = (msel_reg == SEL_OSC_A) || (msel_reg == SEL_OSC_B);

   // next value of the control fields
   always_comb begin
      range_next = range_reg;
      msel_next = msel_reg;
      ssel_next = ssel_reg;
      tap_next = tap_reg;
      mod_next = mod_reg;
      fault_next = fault_reg;
      jump_ev = 1'b0;
      tap_ev = 1'b0;
      if (link.wr) begin
         case (link.addr)
            ADDR_CTL_ONE: begin
               // full 4-bit range field, 15 is the fastest band
               range_next = link.wdata[RANGE_W-1:0];
               // crossing between the high and low band
               if (((range_reg > RANGE_HIGH_EDGE) &&
                    (range_next < RANGE_LOW_EDGE)) ||
                   ((range_reg < RANGE_LOW_EDGE) &&
                    (range_next > RANGE_HIGH_EDGE))) begin
                  jump_ev = 1'b1;
               end
            end
            ADDR_CTL_TWO: begin
               msel_next = link.wdata[SEL_W-1:0];
               ssel_next = link.wdata[SEL_W];
            end
            ADDR_TAP: begin
               tap_next = link.wdata[7:5];
               mod_next = link.wdata[4:0];
               // tap change with every range bit set
               tap_ev = (range_reg == RANGE_MAX) &&
                  (link.wdata != {tap_reg, mod_reg});
            end
            ADDR_IFG: begin
               fault_next = link.wdata[0];
            end
            default: begin
               fault_next = fault_reg;
            end
         endcase
      end
   end

   // next value of the oscillator state
   always_comb begin
      osc_next = osc_reg;
      dead_next = dead_reg;
      case (osc_reg)
         DCOCS_OFF: begin
            // only the main select or the fault logic wakes it;
            // a sub-main select alone does not
            if (main_osc || fault_reg) begin
               osc_next = DCOCS_RUN;
            end
         end
         DCOCS_RUN: begin
            if (!main_osc && !ssel_reg && !fault_reg) begin
               osc_next = DCOCS_OFF;
            end else if ((jump_ev || tap_ev) && hang_on_jump) begin
               osc_next = DCOCS_HANG;
            end else if (jump_ev || tap_ev) begin
               osc_next = DCOCS_DEAD;
               dead_next = DEAD_W'(DEAD_CYCLES - 1);
            end
         end
         DCOCS_DEAD: begin
            // output frozen until the dead time is up
            if (dead_reg == '0) begin
               osc_next = DCOCS_RUN;
            end else begin
               dead_next = dead_reg - 1'b1;
            end
         end
         DCOCS_HANG: begin
            // only power-up clear recovers
            osc_next = DCOCS_HANG;
         end
         default: begin
            osc_next = DCOCS_OFF;
         end
      endcase
   end

   // oscillator output and glitch free source switching
   always_comb begin
      div_next = div_reg;
      tick_next = tick_reg;
      // a stopping oscillator finishes its low half, then parks high,
      // so a clock still following it never sees a short low pulse
      if ((osc_reg == DCOCS_RUN) ||
          ((osc_reg == DCOCS_OFF) && !tick_reg)) begin
         if (div_reg == 4'(OSC_DIV - 1)) begin
            div_next = 4'h0;
            tick_next = ~tick_reg;
         end else begin
            div_next = div_reg + 4'h1;
         end
      end
      mux_main = main_osc ? tick_reg :
         ((msel_reg == SEL_XT) ? crystal_clock : low_freq_clock);
      mux_sub = ssel_reg ? tick_reg : crystal_clock;
      msrc_next = msrc_reg;
      ssrc_next = ssrc_reg;
      // outputs follow the applied source one cycle late
      mclk_next = ((msrc_reg == SEL_OSC_A) || (msrc_reg == SEL_OSC_B)) ?
         tick_reg : ((msrc_reg == SEL_XT) ? crystal_clock : low_freq_clock);
      sclk_next = ssrc_reg ? tick_reg : crystal_clock;
      // swap only while the old level now launched and the new level
      // are both high; no low phase of either is cut short
      if (mux_main && mclk_next) begin
         msrc_next = msel_reg;
      end
      if (mux_sub && sclk_next) begin
         ssrc_next = ssel_reg;
      end
   end

   // register every state group
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         range_reg <= RANGE_DEFAULT;
         msel_reg <= SEL_OSC_A;
         ssel_reg <= 1'b1;
         tap_reg <= '0;
         mod_reg <= '0;
         fault_reg <= 1'b0;
         osc_reg <= DCOCS_OFF;
         dead_reg <= '0;
         div_reg <= 4'h0;
         tick_reg <= 1'b1;
         mclk_reg <= 1'b1;
         sclk_reg <= 1'b1;
         msrc_reg <= SEL_OSC_A;
         ssrc_reg <= 1'b1;
      end else begin
         range_reg <= range_next;
         msel_reg <= msel_next;
         ssel_reg <= ssel_next;
         tap_reg <= tap_next;
         mod_reg <= mod_next;
         fault_reg <= fault_next;
         osc_reg <= osc_next;
         dead_reg <= dead_next;
         div_reg <= div_next;
         tick_reg <= tick_next;
         mclk_reg <= mclk_next;
         sclk_reg <= sclk_next;
         msrc_reg <= msrc_next;
         ssrc_reg <= ssrc_next;
      end
   end

   // status toward the controller
   assign link.range_q = range_reg;
   assign link.main_sel_q = msel_reg;
   assign link.sub_sel_osc_q = ssel_reg;
   assign link.fault_q = fault_reg;
   assign link.osc_on = (osc_reg == DCOCS_RUN);
   assign link.osc_dead = (osc_reg == DCOCS_DEAD) || (osc_reg == DCOCS_HANG);
   assign link.main_clock = mclk_reg;
   assign link.sub_main_clock = sclk_reg;
endmodule : dcocs_device

// [design/dcocs_host.sv]
// design: software facing controller that drives the clock system fields
`timescale 1ns/1ps
module dcocs_host
   import dcocs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // software port
   input wire logic [3:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata,
   // interrupt
   output logic irq,
   // link to the device
   dcocs_if.host link
);
   import dcocs_pkg::*;
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] rdata_reg, rdata_next;       // read data
   logic [EV_W-1:0] stat_reg, stat_next;    // sticky events
   logic [EV_W-1:0] mask_reg, mask_next;    // event mask
   logic on_reg, dead_reg;                  // previous link levels
   logic [EV_W-1:0] ev;                     // event pulses

   // events from link level edges
   assign ev[EV_START] = link.osc_on && !on_reg;
   assign ev[EV_DEAD] = link.osc_dead && !dead_reg;
   assign ev[EV_HANG] = link.osc_dead && !link.osc_on && !dead_reg &&
      (link.range_q == RANGE_MAX);

   // writes pass straight to the device fields; software keeps
   // the range stepping sequences itself
   assign link.wr = sw_wr && (sw_addr <= ADDR_IFG);
   assign link.addr = sw_addr;
   assign link.wdata = sw_wdata;

   // next read data and interrupt registers
   always_comb begin
      rdata_next = 8'h00;
      stat_next = stat_reg & ~((sw_wr && sw_addr == ADDR_INT_STAT) ?
         sw_wdata[EV_W-1:0] : {EV_W{1'b0}});
      stat_next = stat_next | ev;          // set wins over clear
      mask_next = mask_reg;
      if (sw_wr && sw_addr == ADDR_INT_MASK) begin
         mask_next = sw_wdata[EV_W-1:0];
      end
      if (sw_rd) begin
         case (sw_addr)
            ADDR_CTL_ONE: rdata_next = {4'h0, link.range_q};
            ADDR_CTL_TWO: rdata_next = {5'h00, link.sub_sel_osc_q,
               link.main_sel_q};
            ADDR_IFG: rdata_next = {7'h00, link.fault_q};
            ADDR_STATUS: rdata_next = {4'h0, link.main_clock,
               link.sub_main_clock, link.osc_dead, link.osc_on};
            ADDR_INT_STAT: rdata_next = {5'h00, stat_reg};
            ADDR_INT_MASK: rdata_next = {5'h00, mask_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // register the controller state
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdata_reg <= 8'h00;
         stat_reg <= '0;
         mask_reg <= '0;
         on_reg <= 1'b0;
         dead_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         on_reg <= link.osc_on;
         dead_reg <= link.osc_dead;
      end
   end

   assign sw_rdata = rdata_reg;
   assign irq = |(stat_reg & mask_reg);
endmodule : dcocs_host

// [bench/dcocs_chk.sv]
// checker: concurrent properties on the link between the two ends
`timescale 1ns/1ps
module dcocs_chk
   import dcocs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // link signals
   input wire logic wr,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [3:0] range_q,
   input wire logic [1:0] main_sel_q,
   input wire logic sub_sel_osc_q,
   input wire logic fault_q,
   input wire logic osc_on,
   input wire logic osc_dead,
   input wire logic main_clock,
   input wire logic sub_main_clock
);
   import dcocs_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ------------------------------------------------------------
   // helper terms
   // ------------------------------------------------------------
   // oscillator stopped and not frozen
   wire logic osc_idle = !osc_on && !osc_dead;
   // no clock and no fault asks for the oscillator
   wire logic no_user = main_sel_q[1] && !sub_sel_osc_q && !fault_q;
   // only the sub-main clock asks for it
   wire logic sub_only = main_sel_q[1] && sub_sel_osc_q && !fault_q;
   // range field of the write data
   wire logic [3:0] wr_range = wdata[3:0];
   // range write across the unsafe band while running
   wire logic jump = wr && addr == ADDR_CTL_ONE && osc_on &&
      ((range_q > RANGE_HIGH_EDGE && wr_range < RANGE_LOW_EDGE) ||
      (range_q < RANGE_LOW_EDGE && wr_range > RANGE_HIGH_EDGE));
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   idle_osc_off_a: assert property (
      no_user && !osc_dead |=> !osc_on)
      else $error("oscillator runs with no user");
   main_start_a: assert property (
      !main_sel_q[1] && osc_idle |=> osc_on)
      else $error("main select did not start oscillator");
   sub_no_start_a: assert property (
      sub_only && osc_idle |=> !osc_on)
      else $error("sub-main select alone started oscillator");
   sub_stays_high_a: assert property (
      (sub_only && osc_idle) [*6] |-> sub_main_clock)
      else $error("sub-main clock not held high");
   fault_start_a: assert property (
      $rose(fault_q) && !osc_dead |=> osc_on)
      else $error("fault flag did not start oscillator");
   range_default_a: assert property (
      $rose(nrst) |-> range_q == RANGE_DEFAULT)
      else $error("range not default after reset");
   range_follow_a: assert property (
      wr && addr == ADDR_CTL_ONE |=> range_q == $past(wr_range))
      else $error("range field not taken");
   band_dead_a: assert property (
      jump |=> osc_dead [*8])
      else $error("band jump gave no dead time");
   main_low_whole_a: assert property (
      $fell(main_clock) |=> !main_clock)
      else $error("runt low pulse on main clock");
   sub_low_whole_a: assert property (
      $fell(sub_main_clock) |=> !sub_main_clock)
      else $error("runt low pulse on sub-main clock");
   // main scenarios reached
   cover property (jump);
   cover property ($rose(fault_q));
   cover property ((sub_only && osc_idle) [*6]);
endmodule : dcocs_chk

// [bench/testbench.sv]
// testbench: drives the software port and checks both ends together
`timescale 1ns/1ps
module testbench;
   import dcocs_pkg::*;
   // clock, reset and source clocks
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic crystal_clock = 1'b1;
   logic low_freq_clock = 1'b1;
   logic hang_on_jump = 1'b0;
   logic [3:0] src_cnt = 4'h0;
   // software port
   logic [3:0] sw_addr = 4'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [7:0] sw_rdata;
   logic irq;
   // bookkeeping
   int fail_count = 0;
   int n_compared = 0;
   int r;
   dcocs_if i_dcocs_if ();
   dcocs_device i_dcocs_device (.ref_clk(ref_clk), .nrst(nrst),
      .crystal_clock(crystal_clock), .low_freq_clock(low_freq_clock),
      .hang_on_jump(hang_on_jump), .link(i_dcocs_if.device));
   dcocs_host i_dcocs_host (.ref_clk(ref_clk), .nrst(nrst),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .irq(irq), .link(i_dcocs_if.host));
   dcocs_chk i_dcocs_chk (.ref_clk(ref_clk), .nrst(nrst),
      .wr(i_dcocs_if.wr), .addr(i_dcocs_if.addr), .wdata(i_dcocs_if.wdata),
      .range_q(i_dcocs_if.range_q), .main_sel_q(i_dcocs_if.main_sel_q),
      .sub_sel_osc_q(i_dcocs_if.sub_sel_osc_q),
      .fault_q(i_dcocs_if.fault_q), .osc_on(i_dcocs_if.osc_on),
      .osc_dead(i_dcocs_if.osc_dead), .main_clock(i_dcocs_if.main_clock),
      .sub_main_clock(i_dcocs_if.sub_main_clock));
   // 40 ns clock period
   always #20 ref_clk = ~ref_clk;
   // source clocks: crystal halves of 2 cycles, slow source of 8
   always @(posedge ref_clk) begin
      src_cnt <= src_cnt + 4'h1;
      crystal_clock <= src_cnt[1];
      low_freq_clock <= src_cnt[3];
   end
   // ------------------------------------------------------------
   // access and compare tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one-cycle write strobe, settled 1 ns after the taking edge
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge ref_clk);
      sw_wr <= 1'b0;
      #1;
   endtask : wr_reg
   // one-cycle read strobe, data taken in the cycle after it
   task automatic rd_chk(input string what, input logic [3:0] a,
      input logic [7:0] m, input logic [7:0] exp);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge ref_clk);
      sw_rd <= 1'b0;
      #1;
      check(what, sw_rdata & m, exp);
   endtask : rd_chk
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      rd_chk("range", ADDR_CTL_ONE, 8'hFF, 8'h07);
      rd_chk("sources", ADDR_CTL_TWO, 8'hFF, 8'h04);
      rd_chk("osc on", ADDR_STATUS, 8'h03, 8'h01);
      rd_chk("unmapped", 4'hF, 8'hFF, 8'h00);
      $display("test reset done");
      // single steps never cross the unsafe band
      for (r = 0; r < 16; r++) begin
         wr_reg(ADDR_CTL_ONE, 8'(r));
         rd_chk("range step", ADDR_CTL_ONE, 8'h0F, 8'(r));
      end
      rd_chk("no dead", ADDR_STATUS, 8'h03, 8'h01);
      $display("test range codes done");
      // jump down from 15 to 3 with events unmasked
      wr_reg(ADDR_INT_STAT, 8'h07);
      wr_reg(ADDR_INT_MASK, 8'h07);
      check("irq idle", {7'h00, irq}, 8'h00);
      wr_reg(ADDR_CTL_ONE, 8'h03);
      rd_chk("dead", ADDR_STATUS, 8'h03, 8'h02);
      rd_chk("dead event", ADDR_INT_STAT, 8'h02, 8'h02);
      check("irq dead", {7'h00, irq}, 8'h01);
      repeat (DEAD_CYCLES + 20) @(posedge ref_clk);
      rd_chk("dead over", ADDR_STATUS, 8'h03, 8'h01);
      // jump up from 3 to 15 with the event masked
      wr_reg(ADDR_INT_STAT, 8'h07);
      wr_reg(ADDR_INT_MASK, 8'h00);
      wr_reg(ADDR_CTL_ONE, 8'h0F);
      rd_chk("dead up", ADDR_STATUS, 8'h03, 8'h02);
      rd_chk("top event", ADDR_INT_STAT, 8'h04, 8'h04);
      check("irq masked", {7'h00, irq}, 8'h00);
      wr_reg(ADDR_INT_MASK, 8'h02);
      check("irq unmasked", {7'h00, irq}, 8'h01);
      wr_reg(ADDR_INT_STAT, 8'h02);
      check("irq cleared", {7'h00, irq}, 8'h00);
      repeat (DEAD_CYCLES + 20) @(posedge ref_clk);
      // step down through 13, change taps away from the top range
      wr_reg(ADDR_CTL_ONE, 8'h0D);
      rd_chk("stepped down", ADDR_STATUS, 8'h03, 8'h01);
      wr_reg(ADDR_CTL_ONE, 8'h07);
      wr_reg(ADDR_TAP, 8'h5A);
      rd_chk("tap at seven", ADDR_STATUS, 8'h03, 8'h01);
      // back up to the top range without a band jump
      wr_reg(ADDR_CTL_ONE, 8'h0C);
      wr_reg(ADDR_CTL_ONE, 8'h0F);
      rd_chk("stepped up", ADDR_STATUS, 8'h03, 8'h01);
      $display("test dead time done");
      // crystal on both clocks, then sub-main alone on the oscillator
      wr_reg(ADDR_CTL_TWO, 8'h02);
      rd_chk("osc off", ADDR_STATUS, 8'h03, 8'h00);
      wr_reg(ADDR_CTL_TWO, 8'h06);
      repeat (6) @(posedge ref_clk);
      for (r = 0; r < 4; r++) begin
         rd_chk("sub high", ADDR_STATUS, 8'h07, 8'h04);
      end
      // fault flag starts it, clearing both users stops it
      wr_reg(ADDR_IFG, 8'h01);
      rd_chk("fault start", ADDR_STATUS, 8'h03, 8'h01);
      rd_chk("fault flag", ADDR_IFG, 8'h01, 8'h01);
      wr_reg(ADDR_IFG, 8'h00);
      wr_reg(ADDR_CTL_TWO, 8'h02);
      rd_chk("stop again", ADDR_STATUS, 8'h03, 8'h00);
      // both oscillator codes of the main select
      for (r = 0; r < 2; r++) begin
         wr_reg(ADDR_CTL_TWO, 8'(r));
         rd_chk("main code", ADDR_STATUS, 8'h03, 8'h01);
         wr_reg(ADDR_CTL_TWO, 8'h02);
         rd_chk("main off", ADDR_STATUS, 8'h03, 8'h00);
      end
      $display("test source select done");
      // tap change at range 15 hangs until the next reset
      wr_reg(ADDR_CTL_TWO, 8'h00);
      @(posedge ref_clk);
      hang_on_jump <= 1'b1;
      wr_reg(ADDR_TAP, 8'hA5);
      rd_chk("tap dead", ADDR_STATUS, 8'h03, 8'h02);
      repeat (DEAD_CYCLES + 20) @(posedge ref_clk);
      rd_chk("tap hang", ADDR_STATUS, 8'h03, 8'h02);
      // second reset in mid-run clears the hang
      @(posedge ref_clk);
      nrst <= 1'b0;
      hang_on_jump <= 1'b0;
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      rd_chk("range again", ADDR_CTL_ONE, 8'hFF, 8'h07);
      rd_chk("osc again", ADDR_STATUS, 8'h03, 8'h01);
      rd_chk("start event", ADDR_INT_STAT, 8'h01, 8'h01);
      // three-step start straight after reset
      wr_reg(ADDR_TAP, 8'h00);
      wr_reg(ADDR_CTL_ONE, 8'h0A);
      wr_reg(ADDR_TAP, 8'hA5);
      rd_chk("three step", ADDR_STATUS, 8'h03, 8'h01);
      rd_chk("range target", ADDR_CTL_ONE, 8'hFF, 8'h0A);
      $display("test hang and reset done");
      report_and_stop();
   end
   // watchdog: the sequence needs about 1800 cycles
   initial begin
      repeat (6000) @(posedge ref_clk);
      fail_count++;
      report_and_stop();
   end
endmodule : testbench
